//--- sim/acr_load_src.sv
// Purpose: load measurement unit model, one value per full step
// Assumes: caller sends one measurement at a time
// Notes:   stale value is inverted so a stray sample shows up
`timescale 1ns/1ps
module acr_load_src (
    // Clock
    input  wire       CLK_IN,
    // Measurement
    output reg  [9:0] LOAD_MEASUREMENT_VALUE_IN = 10'h155,
    output reg        LOAD_VALID_IN = 1'b0
);
    // One-cycle strobe, then three idle edges so the result has landed
    task send(input logic [9:0] v);
        @(posedge CLK_IN);
        LOAD_VALID_IN <= 1'b1;
        LOAD_MEASUREMENT_VALUE_IN <= v;
        @(posedge CLK_IN);
        LOAD_VALID_IN <= 1'b0;
        LOAD_MEASUREMENT_VALUE_IN <= ~v;
        repeat (3) @(posedge CLK_IN);
    endtask
endmodule

//--- sim/acr_regulator_chk.sv
// Purpose: port-level checks of the current regulator
// Assumes: run current and minimum select may change at any time, even while regulating
// Notes:   ready_q masks the first edge after reset
`timescale 1ns/1ps
`include "acr_defs.vh"
module acr_regulator_chk (
    // Clock, reset and inputs
    input wire                    CLK_IN,
    input wire                    RST_N_IN,
    input wire [`ACR_LOAD_W-1:0]  LOAD_MEASUREMENT_VALUE_IN,
    input wire                    LOAD_VALID_IN,
    input wire                    LOAD_FILTER_EN_IN,
    input wire [`ACR_VEL_W-1:0]   MEASURED_STEP_TIME_IN,
    input wire                    STANDSTILL_IN,
    input wire                    EXT_STEP_DIR_MODE_IN,
    input wire [1:0]              CURRENT_INCREMENT_STEP_IN,
    input wire [`ACR_SET_W-1:0]   LOWER_LOAD_THRESHOLD_IN,
    input wire                    MIN_QUARTER_SEL_IN,
    input wire [`ACR_VEL_W-1:0]   LOWER_VELOCITY_THRESHOLD_IN,
    input wire [`ACR_VEL_W-1:0]   UPPER_VELOCITY_THRESHOLD_IN,
    input wire [`ACR_SCALE_W-1:0] RUN_CURRENT_SETTING_IN,
    input wire [`ACR_SCALE_W-1:0] HOLD_CURRENT_SETTING_IN,
    // Outputs
    input wire [`ACR_SCALE_W-1:0] ACTUAL_CURRENT_SCALE_OUT,
    input wire [`ACR_SCALE_W-1:0] COIL_CURRENT_SCALE_OUT,
    input wire                    REGULATION_ACTIVE_OUT,
    input wire                    STALL_STOP_ENABLE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic ready_q;
    wire [4:0] floor_w = MIN_QUARTER_SEL_IN ? RUN_CURRENT_SETTING_IN >> 2 : RUN_CURRENT_SETTING_IN >> 1;
    wire win_w = (EXT_STEP_DIR_MODE_IN || MEASURED_STEP_TIME_IN <= LOWER_VELOCITY_THRESHOLD_IN) &&
                 MEASURED_STEP_TIME_IN >= UPPER_VELOCITY_THRESHOLD_IN && !STANDSTILL_IN;
    // Outputs hold reset values until the first edge after release
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN)
            ready_q <= 1'b0;
        else
            ready_q <= 1'b1;
    end
    // Raised scale, capped at the run current
    function automatic logic [4:0] inc_cap(input logic [4:0] a, input logic [1:0] s, input logic [4:0] r);
        logic [5:0] t;
        t = {1'b0, a} + (6'h01 << s);
        inc_cap = (t > {1'b0, r}) ? r : t[4:0];
    endfunction
    sequence s_low;
        REGULATION_ACTIVE_OUT && LOAD_VALID_IN && !LOAD_FILTER_EN_IN &&
        LOAD_MEASUREMENT_VALUE_IN < {LOWER_LOAD_THRESHOLD_IN, 5'h00};
    endsequence
    sequence s_stay;
        REGULATION_ACTIVE_OUT [*2];
    endsequence
    AST_CAP_RUN: assert property (ready_q && $stable(RUN_CURRENT_SETTING_IN) |->
        ACTUAL_CURRENT_SCALE_OUT <= RUN_CURRENT_SETTING_IN) else $error("Scale above run current");
    AST_FLOOR: assert property (ready_q && REGULATION_ACTIVE_OUT && $stable(floor_w) |->
        ACTUAL_CURRENT_SCALE_OUT >= floor_w) else $error("Scale below minimum");
    AST_IDLE_RUN: assert property ((ready_q && !REGULATION_ACTIVE_OUT) [*2] ##0 $stable(RUN_CURRENT_SETTING_IN)
        |-> ACTUAL_CURRENT_SCALE_OUT == RUN_CURRENT_SETTING_IN) else $error("Idle scale not run current");
    AST_COIL_HOLD: assert property (ready_q && STANDSTILL_IN |=>
        COIL_CURRENT_SCALE_OUT == $past(HOLD_CURRENT_SETTING_IN)) else $error("Standstill coil not hold");
    AST_COIL_MOVE: assert property (ready_q && !STANDSTILL_IN |=>
        COIL_CURRENT_SCALE_OUT == ACTUAL_CURRENT_SCALE_OUT) else $error("Moving coil not scale");
    AST_STALL_WIN: assert property (ready_q |=> STALL_STOP_ENABLE_OUT == $past(win_w))
        else $error("Stall stop enable wrong");
    AST_ACTIVE: assert property (ready_q |=>
        REGULATION_ACTIVE_OUT == $past(win_w && LOWER_LOAD_THRESHOLD_IN != 4'h0)) else $error("Active flag wrong");
    AST_ON_EVENT: assert property (ready_q && $stable(REGULATION_ACTIVE_OUT) && $stable(RUN_CURRENT_SETTING_IN) &&
        REGULATION_ACTIVE_OUT && $changed(ACTUAL_CURRENT_SCALE_OUT) |-> $past(LOAD_VALID_IN, 2))
        else $error("Scale moved without measurement");
    AST_INC: assert property (s_low ##1 s_stay |-> ACTUAL_CURRENT_SCALE_OUT ==
        inc_cap($past(ACTUAL_CURRENT_SCALE_OUT), $past(CURRENT_INCREMENT_STEP_IN), RUN_CURRENT_SETTING_IN))
        else $error("Increment wrong");
endmodule
bind acr_regulator acr_regulator_chk u_chk (.*);

//--- sim/tb.sv
// Purpose: self-checking bench for the adaptive current regulator
// Assumes: settings held still while a measurement is in flight
// Notes:   signals share port names so instances bind by name
`timescale 1ns/1ps
module tb;
    logic        CLK_IN = 1'b0, RST_N_IN = 1'b0, LOAD_FILTER_EN_IN = 1'b0, STANDSTILL_IN = 1'b0;
    logic        EXT_STEP_DIR_MODE_IN = 1'b0, MIN_QUARTER_SEL_IN = 1'b0;
    logic [1:0]  CURRENT_INCREMENT_STEP_IN = 2'h0, DECREMENT_READING_COUNT_IN = 2'h3;
    logic [3:0]  LOWER_LOAD_THRESHOLD_IN = 4'h2, UPPER_THRESHOLD_HYSTERESIS_IN = 4'h1;
    logic [19:0] MEASURED_STEP_TIME_IN = 20'h00064, LOWER_VELOCITY_THRESHOLD_IN = 20'h000c8;
    logic [19:0] UPPER_VELOCITY_THRESHOLD_IN = 20'h00032;
    logic [4:0]  RUN_CURRENT_SETTING_IN = 5'h14, HOLD_CURRENT_SETTING_IN = 5'h07, e;
    wire  [9:0]  LOAD_MEASUREMENT_VALUE_IN;
    wire         LOAD_VALID_IN, REGULATION_ACTIVE_OUT, STALL_STOP_ENABLE_OUT;
    wire  [4:0]  ACTUAL_CURRENT_SCALE_OUT, COIL_CURRENT_SCALE_OUT;
    int          n_errors = 0, tests_run = 0, cyc = 0, cnt [4] = '{32, 8, 2, 1};
    // Velocity cases: step time, ext mode, standstill, zero minimum, expected active and stall
    logic [19:0] st [6] = '{20'h000c9, 20'h000c9, 20'h00031, 20'h00032, 20'h000c8, 20'h000c8};
    logic [5:0]  ex = 6'h02, ss = 6'h20, mz = 6'h10, ea = 6'h0a, es = 6'h1a;
    acr_regulator u_dut (.*);
    acr_load_src  u_src (.*);
    always #10 CLK_IN = ~CLK_IN;
    task chk(input string nm, input logic [4:0] s, input logic [4:0] e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task hi(input int n, input logic [9:0] v);
        repeat (n) u_src.send(v);
    endtask
    task wt;
        repeat (4) @(posedge CLK_IN);
    endtask
    task results;
        $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Cut a hang short; whole run needs well under a thousand cycles
    always @(posedge CLK_IN) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            results;
        end
    end
    initial begin
        repeat (2) @(posedge CLK_IN);
        chk("scale in reset", ACTUAL_CURRENT_SCALE_OUT, 5'h1f);
        RST_N_IN <= 1'b1;
        wt;
        chk("scale at start", ACTUAL_CURRENT_SCALE_OUT, 5'h14);
        $display("Test reset done");
        for (int d = 3; d >= 0; d--) begin
            DECREMENT_READING_COUNT_IN <= 2'(d);
            e = 5'h14 - 5'(3 - d);
            hi(cnt[d] - 1, 10'h080);
            chk("scale before decrement", ACTUAL_CURRENT_SCALE_OUT, e);
            hi(1, 10'h080);
            chk("scale after decrement", ACTUAL_CURRENT_SCALE_OUT, e - 5'h01);
        end
        DECREMENT_READING_COUNT_IN <= 2'h3;
        hi(8, 10'h3ff);
        chk("half floor", ACTUAL_CURRENT_SCALE_OUT, 5'h0a);
        MIN_QUARTER_SEL_IN <= 1'b1;
        hi(6, 10'h3ff);
        chk("quarter floor", ACTUAL_CURRENT_SCALE_OUT, 5'h05);
        $display("Test decrement done");
        e = 5'h05;
        // Last pass repeats the largest step to hit the run current cap
        for (int i = 0; i < 5; i++) begin
            CURRENT_INCREMENT_STEP_IN <= (i > 3) ? 2'h3 : 2'(i);
            e = (i > 3) ? 5'h14 : e + (5'h01 << i);
            hi(1, 10'h03f);
            chk("scale after increment", ACTUAL_CURRENT_SCALE_OUT, e);
        end
        DECREMENT_READING_COUNT_IN <= 2'h2;
        hi(1, 10'h080);
        hi(1, 10'h064);
        hi(1, 10'h080);
        chk("count cleared by in-band", ACTUAL_CURRENT_SCALE_OUT, 5'h14);
        hi(1, 10'h080);
        chk("two high readings", ACTUAL_CURRENT_SCALE_OUT, 5'h13);
        LOAD_FILTER_EN_IN <= 1'b1;
        DECREMENT_READING_COUNT_IN <= 2'h3;
        hi(3, 10'h080);
        chk("filter partial group", ACTUAL_CURRENT_SCALE_OUT, 5'h13);
        hi(1, 10'h080);
        chk("filter full group", ACTUAL_CURRENT_SCALE_OUT, 5'h12);
        LOAD_FILTER_EN_IN <= 1'b0;
        $display("Test increment and filter done");
        for (int k = 0; k < 6; k++) begin
            MEASURED_STEP_TIME_IN <= st[k];
            EXT_STEP_DIR_MODE_IN <= ex[k];
            STANDSTILL_IN <= ss[k];
            LOWER_LOAD_THRESHOLD_IN <= mz[k] ? 4'h0 : 4'h2;
            wt;
            chk("active", 5'(REGULATION_ACTIVE_OUT), 5'(ea[k]));
            chk("stall stop", 5'(STALL_STOP_ENABLE_OUT), 5'(es[k]));
            chk("scale", ACTUAL_CURRENT_SCALE_OUT, 5'h14);
            chk("coil", COIL_CURRENT_SCALE_OUT, ss[k] ? 5'h07 : 5'h14);
        end
        $display("Test velocity window done");
        results;
    end
endmodule

//--- src/acr_defs.vh
// Purpose: constants for the adaptive current regulator
// Assumes: plain Verilog-2005 include
// Notes:   all widths fixed
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH
`define ACR_SCALE_W      5
`define ACR_LOAD_W       10
`define ACR_SET_W        4
`define ACR_VEL_W        20
`define ACR_CNT_W        6
`define ACR_THR_SHIFT    5
`define ACR_SCALE_MAX    5'h1f
`define ACR_SCALE_RST    5'h1f
`define ACR_CNT_RST      6'h00
`define ACR_DN_CNT_0     6'h20
`define ACR_DN_CNT_1     6'h08
`define ACR_DN_CNT_2     6'h02
`define ACR_DN_CNT_3     6'h01
`define ACR_FILT_LEN     2'h3
`endif

//--- src/acr_load_filter.v
// Purpose: optional four-sample averaging of the load measurement
// Assumes: load_valid_in pulses one cycle per new measurement
// Notes:   filtered output appears only every fourth sample
`timescale 1ns/1ps
`include "acr_defs.vh"
module acr_load_filter (
    // Clock and reset
    input  wire                      clk_in,
    input  wire                      rst_n_in,
    // Control
    input  wire                      filter_en_in,
    // Raw measurement
    input  wire [`ACR_LOAD_W-1:0]    load_in,
    input  wire                      load_valid_in,
    // Result
    output reg  [`ACR_LOAD_W-1:0]    load_out,
    output reg                       load_valid_out
);
    reg  [1:0]              idx_q;
    reg  [`ACR_LOAD_W+1:0]  sum_q;
    wire [`ACR_LOAD_W+1:0]  sum_d;

    assign sum_d = sum_q + {2'h0, load_in};

    // Accumulate four samples, shift to average; pass through when off
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idx_q          <= 2'h0;
            sum_q          <= {(`ACR_LOAD_W+2){1'b0}};
            load_out       <= {`ACR_LOAD_W{1'b0}};
            load_valid_out <= 1'b0;
        end else begin
            load_valid_out <= 1'b0;
            if (load_valid_in) begin
                if (!filter_en_in) begin
                    load_out       <= load_in;
                    load_valid_out <= 1'b1;
                    idx_q          <= 2'h0;
                    sum_q          <= {(`ACR_LOAD_W+2){1'b0}};
                end else if (idx_q == `ACR_FILT_LEN) begin
                    load_out       <= sum_d[`ACR_LOAD_W+1:2];
                    load_valid_out <= 1'b1;
                    idx_q          <= 2'h0;
                    sum_q          <= {(`ACR_LOAD_W+2){1'b0}};
                end else begin
                    idx_q <= idx_q + 2'h1;
                    sum_q <= sum_d;
                end
            end
        end
    end
endmodule

//--- src/acr_regulator.v
// Purpose: load-adaptive coil current scale regulator
// Assumes: inputs synchronous to CLK_IN (50 MHz); one load value per full step
// Notes:   settings are plain ports; scale output is registered
//
// Summary of operation
// - Load below lower threshold raises scale by 1, 2, 4 or 8.
// - Lower scale by one after 32, 8, 2 or 1 high readings.
// - Scale never drops below half or quarter of run current.
// - Step time above lower velocity threshold disables regulation and stall stop.
// - Lower velocity threshold ignored in external step/direction mode.
// - Velocity above upper threshold disables regulation and stall stop.
// - Report present scale 0..31, bounded by run current and minimum.
// - Filter bit averages four measurements, quartering update rate.
// - Outside regulation use run current when moving, hold current at standstill.
// - Lower threshold is minimum setting times 32; zero disables regulation.
// - Upper threshold is (minimum plus hysteresis plus one) times 32.
// - Regulation evaluated once per new load measurement.
// - Lower velocity met when step time is at most its threshold.
`timescale 1ns/1ps
`include "acr_defs.vh"
module acr_regulator (
    // Clock and reset
    input  wire                      CLK_IN,
    input  wire                      RST_N_IN,
    // Load measurement
    input  wire [`ACR_LOAD_W-1:0]    LOAD_MEASUREMENT_VALUE_IN,
    input  wire                      LOAD_VALID_IN,
    input  wire                      LOAD_FILTER_EN_IN,
    // Velocity measurement
    input  wire [`ACR_VEL_W-1:0]     MEASURED_STEP_TIME_IN,
    input  wire                      STANDSTILL_IN,
    input  wire                      EXT_STEP_DIR_MODE_IN,
    // Regulation settings
    input  wire [1:0]                CURRENT_INCREMENT_STEP_IN,
    input  wire [1:0]                DECREMENT_READING_COUNT_IN,
    input  wire [`ACR_SET_W-1:0]     LOWER_LOAD_THRESHOLD_IN,
    input  wire [`ACR_SET_W-1:0]     UPPER_THRESHOLD_HYSTERESIS_IN,
    input  wire                      MIN_QUARTER_SEL_IN,
    input  wire [`ACR_VEL_W-1:0]     LOWER_VELOCITY_THRESHOLD_IN,
    input  wire [`ACR_VEL_W-1:0]     UPPER_VELOCITY_THRESHOLD_IN,
    input  wire [`ACR_SCALE_W-1:0]   RUN_CURRENT_SETTING_IN,
    input  wire [`ACR_SCALE_W-1:0]   HOLD_CURRENT_SETTING_IN,
    // Status and setpoint
    output reg  [`ACR_SCALE_W-1:0]   ACTUAL_CURRENT_SCALE_OUT,
    output reg  [`ACR_SCALE_W-1:0]   COIL_CURRENT_SCALE_OUT,
    output reg                       REGULATION_ACTIVE_OUT,
    output reg                       STALL_STOP_ENABLE_OUT
);
    // One-hot regulator states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_REG  = 2'b10;

    reg  [1:0]               state_q;
    reg  [1:0]               state_d;
    reg  [`ACR_SCALE_W-1:0]  scale_q;
    reg  [`ACR_SCALE_W-1:0]  scale_d;
    reg  [`ACR_CNT_W-1:0]    hi_cnt_q;
    reg  [`ACR_CNT_W-1:0]    hi_cnt_d;
    wire [`ACR_LOAD_W-1:0]   filt_load;
    wire                     filt_valid;
    wire [`ACR_LOAD_W:0]     lower_thr_full;
    wire [`ACR_LOAD_W-1:0]   lower_thr;
    wire [`ACR_LOAD_W:0]     upper_thr;
    wire [`ACR_SCALE_W-1:0]  min_scale;
    wire                     vel_low_ok;
    wire                     vel_high_ok;
    wire                     vel_ok;
    wire                     reg_en;
    wire [`ACR_SCALE_W:0]    inc_sum;
    wire [`ACR_CNT_W-1:0]    dn_target;

    // Threshold scaling by 32, reused for both thresholds
    function [`ACR_LOAD_W:0] thr_scale;
        input [`ACR_SET_W:0] setting;
        begin
            thr_scale = {1'b0, setting, {`ACR_THR_SHIFT{1'b0}}};
        end
    endfunction

    // High readings needed per decrement; lowering is never urgent, so counts run long
    function [`ACR_CNT_W-1:0] dn_count;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    dn_count = `ACR_DN_CNT_0;
                2'h1:    dn_count = `ACR_DN_CNT_1;
                2'h2:    dn_count = `ACR_DN_CNT_2;
                default: dn_count = `ACR_DN_CNT_3;
            endcase
        end
    endfunction

    // Keep a candidate scale between the floor and the run setting;
    // the run setting may be lowered while regulating, so both ends are live
    function [`ACR_SCALE_W-1:0] bound_scale;
        input [`ACR_SCALE_W-1:0] cand;
        input [`ACR_SCALE_W-1:0] high_lim;
        input [`ACR_SCALE_W-1:0] low_lim;
        begin
            if (cand > high_lim) begin
                bound_scale = high_lim;
            end else if (cand < low_lim) begin
                bound_scale = low_lim;
            end else begin
                bound_scale = cand;
            end
        end
    endfunction

    // Load path, optionally averaged
    acr_load_filter u_filter (
        .clk_in         (CLK_IN),
        .rst_n_in       (RST_N_IN),
        .filter_en_in   (LOAD_FILTER_EN_IN),
        .load_in        (LOAD_MEASUREMENT_VALUE_IN),
        .load_valid_in  (LOAD_VALID_IN),
        .load_out       (filt_load),
        .load_valid_out (filt_valid)
    );

    // Thresholds and bounds
    assign lower_thr_full = thr_scale({1'b0, LOWER_LOAD_THRESHOLD_IN});
    // Top bit is always clear: fifteen times 32 still fits the load width
    assign lower_thr      = lower_thr_full[`ACR_LOAD_W-1:0];
    assign upper_thr = thr_scale({1'b0, LOWER_LOAD_THRESHOLD_IN}
                       + {1'b0, UPPER_THRESHOLD_HYSTERESIS_IN} + 5'h01);
    // Minimum is the run setting halved or quartered, rounded down;
    // a run setting of one therefore gives a floor of zero
    assign min_scale = MIN_QUARTER_SEL_IN ?
                       (RUN_CURRENT_SETTING_IN >> 2) :
                       (RUN_CURRENT_SETTING_IN >> 1);

    // Velocity window; low limit skipped in step/dir mode
    assign vel_low_ok  = EXT_STEP_DIR_MODE_IN ||
                         (MEASURED_STEP_TIME_IN <= LOWER_VELOCITY_THRESHOLD_IN);
    // Larger step time means slower; above upper velocity means shorter time
    assign vel_high_ok = (MEASURED_STEP_TIME_IN >= UPPER_VELOCITY_THRESHOLD_IN);
    assign vel_ok      = vel_low_ok && vel_high_ok && !STANDSTILL_IN;
    assign reg_en      = vel_ok && (LOWER_LOAD_THRESHOLD_IN != 4'h0);

    assign inc_sum = {1'b0, scale_q} + ({{`ACR_SCALE_W{1'b0}}, 1'b1}
                     << CURRENT_INCREMENT_STEP_IN);

    // Decrement count selection
    assign dn_target = dn_count(DECREMENT_READING_COUNT_IN);

    // Next-state and scale update
    always @* begin
        state_d  = state_q;
        scale_d  = scale_q;
        hi_cnt_d = hi_cnt_q;
        case (state_q)
            ST_IDLE: begin
                // Plain run current while idle, so regulation restarts from full
                scale_d  = RUN_CURRENT_SETTING_IN;
                hi_cnt_d = `ACR_CNT_RST;
                if (reg_en) begin
                    state_d = ST_REG;
                end
            end
            ST_REG: begin
                // A valid on the entry edge is dropped; scale starts from run
                if (!reg_en) begin
                    state_d  = ST_IDLE;
                    scale_d  = RUN_CURRENT_SETTING_IN;
                    hi_cnt_d = `ACR_CNT_RST;
                end else if (filt_valid) begin
                    if (filt_load < lower_thr) begin
                        hi_cnt_d = `ACR_CNT_RST;
                        if (inc_sum > {1'b0, RUN_CURRENT_SETTING_IN}) begin
                            scale_d = RUN_CURRENT_SETTING_IN;
                        end else begin
                            scale_d = inc_sum[`ACR_SCALE_W-1:0];
                        end
                    end else if ({1'b0, filt_load} >= upper_thr) begin
                        // Count this reading; decrement once the target is reached,
                        // so a target of one lowers the scale on every high reading
                        if (hi_cnt_q + 6'h01 >= dn_target) begin
                            hi_cnt_d = `ACR_CNT_RST;
                            if (scale_q > min_scale) begin
                                scale_d = scale_q - 5'h01;
                            end
                        end else begin
                            hi_cnt_d = hi_cnt_q + 6'h01;
                        end
                    end else begin
                        hi_cnt_d = `ACR_CNT_RST;
                    end
                end
                // Run setting may drop while regulating; clamp both ways
                scale_d = bound_scale(scale_d, RUN_CURRENT_SETTING_IN, min_scale);
            end
            default: begin
                state_d  = ST_IDLE;
                scale_d  = RUN_CURRENT_SETTING_IN;
                hi_cnt_d = `ACR_CNT_RST;
            end
        endcase
    end

    // State registers and registered outputs
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q                  <= ST_IDLE;
            scale_q                  <= `ACR_SCALE_RST;
            hi_cnt_q                 <= `ACR_CNT_RST;
            ACTUAL_CURRENT_SCALE_OUT <= `ACR_SCALE_RST;
            COIL_CURRENT_SCALE_OUT   <= {`ACR_SCALE_W{1'b0}};
            REGULATION_ACTIVE_OUT    <= 1'b0;
            STALL_STOP_ENABLE_OUT    <= 1'b0;
        end else begin
            state_q                  <= state_d;
            scale_q                  <= scale_d;
            hi_cnt_q                 <= hi_cnt_d;
            ACTUAL_CURRENT_SCALE_OUT <= scale_d;
            // Hold current at standstill, else regulated or plain run
            COIL_CURRENT_SCALE_OUT   <= STANDSTILL_IN ? HOLD_CURRENT_SETTING_IN : scale_d;
            REGULATION_ACTIVE_OUT    <= (state_d == ST_REG);
            STALL_STOP_ENABLE_OUT    <= vel_ok;
        end
    end
endmodule
